// >>> src/pxu_exception_unit.sv
// module: exception sequencing unit of the processor core
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module pxu_exception_unit
  import pxu_pkg::*;
#(
  parameter int EXT_RESET_CYCLES = PXU_EXT_RESET_CYCLES // pulse length
) (
  input wire logic core_clk, // 50 mhz core clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic interrupt_level_pin_2_n, // request level bit 2, low
  input wire logic interrupt_level_pin_1_n, // request level bit 1, low
  input wire logic interrupt_level_pin_0_n, // request level bit 0, low
  input wire pxu_bound_s bound_in, // instruction completion report
  input wire pxu_bus_s bus_in, // bus cycle end report
  input wire pxu_ack_s ack_in, // acknowledge read answer
  input wire logic reset_instr, // reset instruction executed, pulse
  input wire logic exc_done, // core finished vector fetch, pulse
  input wire logic [7:0] reg_addr, // register port address
  input wire logic [15:0] reg_wdata, // register port write data
  input wire logic reg_we, // register write strobe
  input wire logic reg_re, // register read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  output logic go_next, // start next instruction, pulse
  output logic exc_start, // begin exception processing, pulse
  output logic [7:0] exc_vec, // vector number
  output logic [23:0] exc_vec_addr, // vector address
  output logic exc_save, // stack sr and pc for this exception
  output logic [15:0] exc_saved_sr, // status register copy
  output logic [23:0] exc_saved_pc, // program counter to stack
  output logic iack_req, // acknowledge read in progress
  output logic [2:0] iack_level, // level shown on the address bus
  output logic ext_reset, // reset line to external devices
  output logic halted, // processor halted by double fault
  output logic [15:0] sr // live status register
);

  // ----------------------------------------------------------------
  // request level synchroniser and edge capture
  // ----------------------------------------------------------------
  logic [2:0] pin_sync1_reg; // first stage, read only by second
  logic [2:0] pin_sync2_reg; // second stage
  logic [2:0] lvl_reg; // decoded request level
  logic [2:0] lvl_prev_reg; // level one cycle earlier
  logic nmi_pend_reg; // rise to seven seen, not yet taken
  logic rise7; // rise to level seven this cycle

  // two flops on the asynchronous pins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_sync1_reg <= '1; // pins idle high: no request
      pin_sync2_reg <= '1;
    end else begin
      pin_sync1_reg <= {interrupt_level_pin_2_n, interrupt_level_pin_1_n,
                        interrupt_level_pin_0_n};
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // inverted pins give the internal level
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lvl_reg <= PXU_LEVEL_NONE;
      lvl_prev_reg <= PXU_LEVEL_NONE;
    end else begin
      lvl_reg <= ~pin_sync2_reg;
      lvl_prev_reg <= lvl_reg;
    end
  end

  assign rise7 = (lvl_reg == PXU_LEVEL_NMI) &&
                 (lvl_prev_reg != PXU_LEVEL_NMI);

  // ----------------------------------------------------------------
  // sequencer state and boundary decision
  // ----------------------------------------------------------------
  pxu_state_e state_reg; // sequencer state
  logic [15:0] sr_reg; // status register
  logic trace_armed_reg; // trace bit was set when instruction began
  logic trace_pend_reg; // trace owed for completed instruction
  logic g2_pend_reg; // instruction forced exception owed
  logic [7:0] g2_vec_reg; // its vector
  logic [23:0] next_pc_reg; // address of the next instruction
  logic [15:0] next_word_reg; // first word of next instruction
  logic next_legal_reg; // it is legal
  logic next_priv_reg; // it is privileged
  logic [2:0] mask; // current priority mask
  logic irq_ok; // interrupt may be taken now
  logic bus_fault; // bus or address error at cycle end
  logic [7:0] fault_vec; // vector for that fault
  logic [7:0] decode_vec; // vector for next word problems
  logic decode_bad; // next word cannot execute
  logic [7:0] bound_g2_vec; // forced vector from completion report
  logic bound_g2; // completion report forces an exception
  logic bound_exc; // boundary takes a non-interrupt exception

  assign mask = sr_reg[PXU_SR_MASK_LO +: 3];
  // nmi by edge, every level by plain comparison against the mask
  assign irq_ok = (lvl_reg > mask) ||
                  (nmi_pend_reg && lvl_reg == PXU_LEVEL_NMI);
  assign bus_fault = bus_in.cycle_end &&
                     (bus_in.bus_err || bus_in.addr_err);
  assign fault_vec = bus_in.addr_err ? PXU_VEC_ADDR_ERR : PXU_VEC_BUS_ERR;
  // forced and trace beat interrupts; interrupts beat decode faults
  assign bound_exc = g2_pend_reg || trace_pend_reg ||
                     (decode_bad && !irq_ok);

  // forced exceptions of the completed instruction
  always_comb begin
    bound_g2 = 1'b1;
    bound_g2_vec = PXU_VEC_ZERO_DIV;
    if (bound_in.trap) begin
      bound_g2_vec = PXU_VEC_TRAP_BASE + {4'h0, bound_in.trap_num};
    end else if (bound_in.ovf_trap) begin
      bound_g2_vec = PXU_VEC_OVERFLOW;
    end else if (bound_in.bounds_fail) begin
      bound_g2_vec = PXU_VEC_BOUNDS;
    end else if (bound_in.div_zero) begin
      bound_g2_vec = PXU_VEC_ZERO_DIV;
    end else begin
      bound_g2 = 1'b0;
    end
  end

  // next word check: line opcodes, illegal, privilege
  always_comb begin
    decode_bad = 1'b1;
    decode_vec = PXU_VEC_ILLEGAL;
    if (next_word_reg[15:12] == PXU_LINE_A) begin
      decode_vec = PXU_VEC_LINE_A;
    end else if (next_word_reg[15:12] == PXU_LINE_F) begin
      decode_vec = PXU_VEC_LINE_F;
    end else if (!next_legal_reg) begin
      decode_vec = PXU_VEC_ILLEGAL;
    end else if (next_priv_reg && !sr_reg[PXU_SR_S_BIT]) begin
      decode_vec = PXU_VEC_PRIV;
    end else begin
      decode_bad = 1'b0;
    end
  end

  // state machine
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_reg <= PXU_ST_RESET;
    end else begin
      unique case (state_reg)
        PXU_ST_RESET: begin
          state_reg <= PXU_ST_WAIT;
        end
        PXU_ST_RUN: begin
          if (bus_fault) begin
            state_reg <= PXU_ST_WAIT;
          end else if (bound_in.done) begin
            state_reg <= PXU_ST_BOUND;
          end
        end
        PXU_ST_BOUND: begin
          if (bound_exc) begin
            state_reg <= PXU_ST_WAIT;
          end else if (irq_ok) begin
            state_reg <= PXU_ST_ACK;
          end else begin
            state_reg <= PXU_ST_RUN;
          end
        end
        PXU_ST_ACK: begin
          if (ack_in.valid) begin
            state_reg <= PXU_ST_WAIT;
          end
        end
        PXU_ST_WAIT: begin
          if (bus_fault) begin
            state_reg <= PXU_ST_HALT; // double fault
          end else if (exc_done) begin
            state_reg <= PXU_ST_BOUND;
          end
        end
        PXU_ST_HALT: begin
          state_reg <= PXU_ST_HALT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pending exceptions of the completed instruction
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      g2_pend_reg <= 1'b0;
      g2_vec_reg <= PXU_VEC_RESET;
      trace_pend_reg <= 1'b0;
      next_pc_reg <= '0;
      next_word_reg <= '0;
      next_legal_reg <= 1'b1;
      next_priv_reg <= 1'b0;
    end else if (state_reg == PXU_ST_RUN && bus_fault) begin
      g2_pend_reg <= 1'b0; // aborted: no trap, no trace
      trace_pend_reg <= 1'b0;
    end else if (state_reg == PXU_ST_RUN && bound_in.done) begin
      g2_pend_reg <= bound_g2;
      g2_vec_reg <= bound_g2_vec;
      trace_pend_reg <= trace_armed_reg;
      next_pc_reg <= bound_in.next_pc;
      next_word_reg <= bound_in.next_word;
      next_legal_reg <= bound_in.next_legal;
      next_priv_reg <= bound_in.next_priv;
    end else if (state_reg == PXU_ST_BOUND) begin
      if (g2_pend_reg) begin
        g2_pend_reg <= 1'b0;
      end else if (trace_pend_reg) begin
        trace_pend_reg <= 1'b0;
      end else if (decode_bad && !irq_ok) begin
        next_word_reg <= '0; // decode fault is raised once only
        next_legal_reg <= 1'b1;
        next_priv_reg <= 1'b0;
      end
    end
  end

  // trace arming when an instruction begins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trace_armed_reg <= 1'b0;
    end else if (state_reg == PXU_ST_BOUND && !g2_pend_reg &&
                 !trace_pend_reg && !decode_bad && !irq_ok) begin
      trace_armed_reg <= sr_reg[PXU_SR_T_BIT];
    end else if (state_reg != PXU_ST_RUN) begin
      trace_armed_reg <= 1'b0;
    end
  end

  // level seven edge memory; a new edge wins over the take
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nmi_pend_reg <= 1'b0;
    end else if (rise7) begin
      nmi_pend_reg <= 1'b1;
    end else if (state_reg == PXU_ST_BOUND && !g2_pend_reg &&
                 !trace_pend_reg && irq_ok) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status register: exception entry wins over software write
  // ----------------------------------------------------------------
  logic enter; // some exception entry this cycle
  logic irq_take; // interrupt accepted this cycle

  assign irq_take = state_reg == PXU_ST_BOUND && !g2_pend_reg &&
                    !trace_pend_reg && irq_ok;
  assign enter = irq_take || (state_reg == PXU_ST_RUN && bus_fault) ||
                 (state_reg == PXU_ST_BOUND && bound_exc);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sr_reg <= PXU_SR_RESET;
      exc_saved_sr <= '0;
    end else if (enter) begin
      exc_saved_sr <= sr_reg;
      sr_reg[PXU_SR_S_BIT] <= 1'b1;
      sr_reg[PXU_SR_T_BIT] <= 1'b0;
      if (irq_take) begin
        sr_reg[PXU_SR_MASK_LO +: 3] <= lvl_reg;
      end
    end else if (reg_we && reg_addr == PXU_REG_SR) begin
      sr_reg <= reg_wdata; // lowering mask re-enables comparison
    end
  end

  // ----------------------------------------------------------------
  // exception start, vector and acknowledge outputs
  // ----------------------------------------------------------------
  logic [7:0] vec_sel; // vector chosen this cycle
  logic vec_go; // exception starts this cycle

  always_comb begin
    vec_go = 1'b0;
    vec_sel = PXU_VEC_RESET;
    unique case (state_reg)
      PXU_ST_RESET: begin
        vec_go = 1'b1;
      end
      PXU_ST_RUN: begin
        vec_go = bus_fault;
        vec_sel = fault_vec;
      end
      PXU_ST_BOUND: begin
        vec_go = bound_exc;
        if (g2_pend_reg) begin
          vec_sel = g2_vec_reg;
        end else if (trace_pend_reg) begin
          vec_sel = PXU_VEC_TRACE;
        end else begin
          vec_sel = decode_vec;
        end
      end
      PXU_ST_ACK: begin
        vec_go = ack_in.valid;
        if (ack_in.bus_err) begin
          vec_sel = PXU_VEC_SPURIOUS;
        end else if (ack_in.auto_vec) begin
          vec_sel = PXU_VEC_AUTO_BASE + {5'h00, iack_level};
        end else begin
          vec_sel = ack_in.vec;
        end
      end
      PXU_ST_WAIT, PXU_ST_HALT: begin
        vec_go = 1'b0;
      end
    endcase
  end

  // registered exception outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      exc_start <= 1'b0;
      exc_vec <= PXU_VEC_RESET;
      exc_vec_addr <= '0;
      exc_save <= 1'b0;
      exc_saved_pc <= '0;
    end else begin
      exc_start <= vec_go;
      if (vec_go) begin
        exc_vec <= vec_sel;
        exc_vec_addr <= {PXU_VEC_ADDR_HI, vec_sel, PXU_VEC_ADDR_PAD};
        exc_save <= state_reg != PXU_ST_RESET;
        exc_saved_pc <= next_pc_reg;
      end
    end
  end

  // acknowledge read with level on the address bus
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      iack_req <= 1'b0;
      iack_level <= PXU_LEVEL_NONE;
    end else if (irq_take) begin
      iack_req <= 1'b1;
      iack_level <= lvl_reg;
    end else if (state_reg == PXU_ST_ACK && ack_in.valid) begin
      iack_req <= 1'b0;
    end
  end

  // instruction start pulse and halt flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      go_next <= 1'b0;
      halted <= 1'b0;
    end else begin
      go_next <= state_reg == PXU_ST_BOUND && !enter;
      halted <= state_reg == PXU_ST_HALT ||
                (state_reg == PXU_ST_WAIT && bus_fault);
    end
  end

  // ----------------------------------------------------------------
  // reset instruction: external pulse, no vector fetch
  // ----------------------------------------------------------------
  logic [$clog2(EXT_RESET_CYCLES+1)-1:0] ext_cnt_reg; // cycles left

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext_cnt_reg <= '0;
      ext_reset <= 1'b0;
    end else if (reset_instr && state_reg == PXU_ST_RUN) begin
      ext_cnt_reg <= ($bits(ext_cnt_reg))'(EXT_RESET_CYCLES - 1);
      ext_reset <= 1'b1;
    end else if (ext_cnt_reg != '0) begin
      ext_cnt_reg <= ext_cnt_reg - 1'b1;
    end else begin
      ext_reset <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_re) begin
      unique case (reg_addr)
        PXU_REG_SR: reg_rdata <= sr_reg;
        PXU_REG_STATE: reg_rdata <= {4'h0, nmi_pend_reg, lvl_reg,
                                     2'h0, state_reg};
        PXU_REG_LAST_VEC: reg_rdata <= {8'h00, exc_vec};
        default: reg_rdata <= '0; // unmapped reads zero
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  assign sr = sr_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  reset_entry_a: assert property ($fell(sys_rst) |=> exc_start &&
    exc_vec == PXU_VEC_RESET && !exc_save)
    else $error("reset vector not fetched after reset");
  reset_sr_a: assert property ($fell(sys_rst) |-> sr_reg[PXU_SR_S_BIT] &&
    !sr_reg[PXU_SR_T_BIT] && mask == PXU_LEVEL_NMI)
    else $error("reset left wrong status register");
  accept_sr_a: assert property ($rose(iack_req) |-> mask == iack_level &&
    sr_reg[PXU_SR_S_BIT] && !sr_reg[PXU_SR_T_BIT])
    else $error("interrupt entry status wrong");
  mask_inhibit_a: assert property (state_reg == PXU_ST_BOUND &&
    lvl_reg <= mask && !nmi_pend_reg |=> !$rose(iack_req))
    else $error("masked interrupt acknowledged");
  autovector_a: assert property (state_reg == PXU_ST_ACK &&
    ack_in.valid && ack_in.auto_vec && !ack_in.bus_err |=>
    exc_vec == PXU_VEC_AUTO_BASE + {5'h00, iack_level})
    else $error("autovector number wrong");
  spurious_a: assert property (state_reg == PXU_ST_ACK && ack_in.valid &&
    ack_in.bus_err |=> exc_start && exc_vec == PXU_VEC_SPURIOUS)
    else $error("spurious vector not taken");
  vec_addr_a: assert property (exc_start |->
    exc_vec_addr == {14'h0000, exc_vec, 2'h0})
    else $error("vector address not number times four");
  order_g2_a: assert property (state_reg == PXU_ST_BOUND && g2_pend_reg
    |=> exc_start && exc_vec == $past(g2_vec_reg))
    else $error("forced exception not first");
  nmi_edge_a: assert property (rise7 |=> nmi_pend_reg)
    else $error("rise to seven lost");
  ext_reset_a: assert property (reset_instr && state_reg == PXU_ST_RUN &&
    !bus_fault |=> ext_reset && !exc_start)
    else $error("reset instruction misbehaved");

  auto_c: cover property (state_reg == PXU_ST_ACK && ack_in.auto_vec);
  nmi_c: cover property (rise7 ##[1:20] $rose(iack_req));
  trace_c: cover property (exc_start && exc_vec == PXU_VEC_TRACE);
  halt_c: cover property ($rose(halted));

endmodule : pxu_exception_unit

// >>> src/pxu_pkg.sv
// package: constants, states and carriers of the exception sequencing unit
package pxu_pkg;

  // ----------------------------------------------------------------
  // vector numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] PXU_VEC_RESET = 8'h00; // initial stack and pc
  localparam logic [7:0] PXU_VEC_BUS_ERR = 8'h02; // bus error
  localparam logic [7:0] PXU_VEC_ADDR_ERR = 8'h03; // odd address
  localparam logic [7:0] PXU_VEC_ILLEGAL = 8'h04; // illegal first word
  localparam logic [7:0] PXU_VEC_ZERO_DIV = 8'h05; // divisor zero
  localparam logic [7:0] PXU_VEC_BOUNDS = 8'h06; // bounds check
  localparam logic [7:0] PXU_VEC_OVERFLOW = 8'h07; // overflow trap
  localparam logic [7:0] PXU_VEC_PRIV = 8'h08; // privilege violation
  localparam logic [7:0] PXU_VEC_TRACE = 8'h09; // trace
  localparam logic [7:0] PXU_VEC_LINE_A = 8'h0a; // unimplemented 1010
  localparam logic [7:0] PXU_VEC_LINE_F = 8'h0b; // unimplemented 1111
  localparam logic [7:0] PXU_VEC_UNINIT = 8'h0f; // uninitialised peripheral
  localparam logic [7:0] PXU_VEC_SPURIOUS = 8'h18; // nobody answered
  localparam logic [7:0] PXU_VEC_AUTO_BASE = 8'h18; // autovector = base+lvl
  localparam logic [7:0] PXU_VEC_TRAP_BASE = 8'h20; // system-call traps

  // ----------------------------------------------------------------
  // status register layout and opcode classes
  // ----------------------------------------------------------------
  localparam int PXU_SR_T_BIT = 15; // trace bit
  localparam int PXU_SR_S_BIT = 13; // supervisor bit
  localparam int PXU_SR_MASK_LO = 8; // priority mask low bit
  localparam logic [15:0] PXU_SR_RESET = 16'h2700; // supervisor, mask seven
  localparam logic [2:0] PXU_LEVEL_NMI = 3'h7; // non-maskable level
  localparam logic [2:0] PXU_LEVEL_NONE = 3'h0; // no request
  localparam logic [3:0] PXU_LINE_A = 4'ha; // top nibble 1010
  localparam logic [3:0] PXU_LINE_F = 4'hf; // top nibble 1111
  localparam logic [1:0] PXU_VEC_ADDR_PAD = 2'h0; // address bits 1:0
  localparam logic [13:0] PXU_VEC_ADDR_HI = 14'h0000; // address bits 23:10

  // ----------------------------------------------------------------
  // register port map and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] PXU_REG_SR = 8'h00; // status register, rw
  localparam logic [7:0] PXU_REG_STATE = 8'h04; // sequencer state, ro
  localparam logic [7:0] PXU_REG_LAST_VEC = 8'h08; // last vector, ro
  localparam int PXU_EXT_RESET_CYCLES = 16; // external reset pulse

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    PXU_ST_RESET = 6'b000001, // reset entry pending
    PXU_ST_RUN = 6'b000010, // instruction executing
    PXU_ST_BOUND = 6'b000100, // between instructions
    PXU_ST_ACK = 6'b001000, // interrupt acknowledge read
    PXU_ST_WAIT = 6'b010000, // core stacking and fetching vector
    PXU_ST_HALT = 6'b100000 // double fault, only reset leaves
  } pxu_state_e;

  // report from the core at the end of an instruction
  typedef struct packed {
    logic done; // instruction completed, one-cycle pulse
    logic trap; // system-call trap executed
    logic [3:0] trap_num; // trap number
    logic ovf_trap; // overflow_trap_instruction with overflow set
    logic bounds_fail; // bounds_check_instruction out of bounds
    logic div_zero; // signed or unsigned divide by zero
    logic [15:0] next_word; // first word of the next instruction
    logic next_legal; // next word decodes as a legal opcode
    logic next_priv; // next instruction is privileged
    logic [23:0] next_pc; // address of the next instruction
  } pxu_bound_s;

  // bus cycle end report from the core
  typedef struct packed {
    logic cycle_end; // a bus cycle ended this cycle
    logic bus_err; // it ended in bus error
    logic addr_err; // it was an odd word access
  } pxu_bus_s;

  // answer to the interrupt acknowledge read
  typedef struct packed {
    logic valid; // answer present this cycle
    logic auto_vec; // autovector requested
    logic bus_err; // bus error: spurious interrupt
    logic [7:0] vec; // vector number from the device
  } pxu_ack_s;

endpackage : pxu_pkg

// >>> tb/processor_exception_unit_test.sv
// bench: exception sequencing unit against a peripheral model
`timescale 1ns/1ps
module processor_exception_unit_test;
  import pxu_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, reset_instr = 1'b0;
  logic exc_done = 1'b0, reg_we = 1'b0, reg_re = 1'b0, go_next, exc_start;
  logic exc_save, iack_req, ext_reset, halted;
  logic [1:0] pm = 2'h0, pd = 2'h0; // peripheral mode and delay
  logic [2:0] lv_n = 3'h7, iack_level; // request pins, idle high
  logic [7:0] reg_addr = 8'h00, pv = 8'h00, exc_vec;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, sr, exc_saved_sr;
  logic [23:0] exc_vec_addr, exc_saved_pc;
  pxu_bound_s bound_in = '0, b = '0;
  pxu_bus_s bus_in = '0;
  pxu_ack_s ack_in;
  int err_count = 0, comparisons = 0, n_exc = 0, k, i, m;
  always #10 core_clk = ~core_clk;
  always @(negedge core_clk) n_exc += int'(exc_start === 1'b1);
  pxu_exception_unit #(.EXT_RESET_CYCLES(2)) dut (.core_clk, .sys_rst,
    .interrupt_level_pin_2_n(lv_n[2]), .interrupt_level_pin_1_n(lv_n[1]),
    .interrupt_level_pin_0_n(lv_n[0]), .bound_in, .bus_in, .ack_in,
    .reset_instr, .exc_done, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .go_next, .exc_start, .exc_vec, .exc_vec_addr, .exc_save,
    .exc_saved_sr, .exc_saved_pc, .iack_req, .iack_level, .ext_reset,
    .halted, .sr);
  pxu_periph peer (.core_clk, .iack_req, .mode(pm), .vec(pv), .dly(pd),
    .ack_in);
  task stop_test;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // bounded wait for a design output, sampled on falling edges
  task automatic wt(ref logic s);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (s !== 1'b1 && k < 300);
    if (s !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask : wt
  task ex(input logic [7:0] v);
    wt(exc_start);
    chk(exc_vec, v);
    chk(exc_vec_addr, {14'h0000, v, 2'h0});
    @(posedge core_clk) exc_done <= 1'b1;
    @(posedge core_clk) exc_done <= 1'b0;
  endtask : ex
  task fin;
    @(posedge core_clk) bound_in <= b;
    @(posedge core_clk) bound_in.done <= 1'b0;
  endtask : fin
  // vector expected for case j of the completed-instruction sweep
  function automatic logic [7:0] g2_exp(input int j, input logic [3:0] t);
    if (j == 0) return 8'h20 + {4'h0, t}; // system-call trap
    if (j < 4) return 8'(8 - j); // overflow, bounds, zero divide
    return j == 4 ? 8'h04 : 8'(j + 5); // illegal, line a, line f
  endfunction : g2_exp
  task wr(input logic [15:0] d);
    @(posedge core_clk) reg_wdata <= d;
    reg_we <= 1'b1;
    reg_addr <= PXU_REG_SR;
    @(posedge core_clk) reg_we <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk) reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge core_clk) reg_re <= 1'b0;
    @(negedge core_clk) chk(reg_rdata, e);
  endtask : rd
  task irq(input logic [2:0] l, input logic [1:0] md, input logic [7:0] v);
    pm <= md;
    pv <= v;
    pd <= 2'($urandom);
    lv_n <= ~l;
    repeat (4) @(posedge core_clk);
    b.next_pc = 24'($urandom);
    fin();
    wt(iack_req);
    chk(iack_level, l);
    chk(sr[15:8], {5'h04, l});
    chk(exc_saved_sr, 16'h2000 | 16'(m) << 8);
    ex(md == 2'h1 ? 8'h18 + l : md == 2'h2 ? 8'h18 : v);
    chk(exc_saved_pc, b.next_pc);
    lv_n <= 3'h7;
    wt(go_next);
  endtask : irq
  initial begin
    void'($urandom(32'hac4dff0f));
    repeat (2) @(negedge core_clk);
    chk(sr, 16'h2700);
    @(posedge core_clk) sys_rst <= 1'b0;
    ex(PXU_VEC_RESET);
    chk(exc_save, 1'b0);
    wt(go_next);
    b.done = 1'b1;
    for (i = 0; i < 7; i++) begin
      b.trap_num = 4'($urandom);
      {b.trap, b.ovf_trap, b.bounds_fail, b.div_zero} = 4'(8 >> i);
      b.next_legal = i < 4;
      b.next_word = {i == 5 ? 4'ha : i == 6 ? 4'hf : 4'h3, 12'($urandom)};
      fin();
      ex(g2_exp(i, b.trap_num));
      wt(go_next);
    end
    b.next_legal = 1'b1;
    b.next_word[15:12] = 4'h3; // plain opcode again
    wr(16'h0000);
    b.next_priv = 1'b1;
    fin();
    ex(PXU_VEC_PRIV);
    wt(go_next);
    b.next_priv = 1'b0;
    wr(16'h2300);
    lv_n <= 3'h4;
    repeat (4) @(posedge core_clk);
    m = n_exc;
    fin();
    wt(go_next);
    chk(n_exc, m);
    for (i = 0; i < 6; i++) begin
      m = $urandom_range(5, 0);
      wr(16'h2000 | 16'(m) << 8);
      irq(3'(m + $urandom_range(7 - m, 1)), 2'(i % 3),
          i == 0 ? 8'h0f : 8'($urandom_range(255, 64)));
    end
    wr(16'ha700);
    fin();
    wt(go_next);
    @(posedge core_clk) pm <= 2'h1;
    lv_n <= 3'h0;
    repeat (4) @(posedge core_clk);
    b.trap = 1'b1;
    fin();
    ex(8'h20 + b.trap_num);
    ex(PXU_VEC_TRACE);
    ex(8'h1f);
    lv_n <= 3'h7;
    wt(go_next);
    for (i = 0; i < 2; i++) begin
      @(posedge core_clk) bus_in <= {1'b1, i == 0, i == 1};
      @(posedge core_clk) bus_in <= '0;
      ex(8'(2 + i));
      wt(go_next);
    end
    @(posedge core_clk) reset_instr <= 1'b1;
    @(posedge core_clk) reset_instr <= 1'b0;
    m = 0;
    k = n_exc;
    repeat (8) @(negedge core_clk) m += int'(ext_reset === 1'b1);
    chk(m, 2);
    chk(n_exc, k);
    rd(PXU_REG_SR, 16'h2700);
    rd(8'h0c, 16'h0000);
    // double fault halts; only a reset in mid-run leaves halt
    repeat (2) @(posedge core_clk) bus_in <= {1'b1, 1'b1, 1'b0};
    @(posedge core_clk) bus_in <= '0;
    wt(halted);
    chk(halted, 1'b1);
    repeat (2) @(posedge core_clk) sys_rst <= 1'b1;
    @(posedge core_clk) sys_rst <= 1'b0;
    ex(PXU_VEC_RESET);
    chk(halted, 1'b0);
    wt(go_next);
    chk(sr, 16'h2700);
    stop_test();
  end
endmodule : processor_exception_unit_test

// >>> tb/pxu_periph.sv
// partner: interrupting peripheral answering acknowledge reads
`timescale 1ns/1ps
module pxu_periph
  import pxu_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic iack_req, // acknowledge read running
  input wire logic [1:0] mode, // 0 vector, 1 auto, 2 nobody answers
  input wire logic [7:0] vec, // vector the device returns
  input wire logic [1:0] dly, // answer delay in cycles
  output pxu_ack_s ack_in // answer to the core
);
  logic [1:0] n = 2'h0; // cycles waited
  initial ack_in = '0;
  // one-cycle answer; idle data lines toggle so stale data never matches
  always @(posedge core_clk) begin
    n <= iack_req && !ack_in.valid ? n + 2'h1 : 2'h0;
    if (iack_req && !ack_in.valid && n >= dly)
      ack_in <= {1'b1, mode == 2'h1, mode == 2'h2, vec};
    else
      ack_in <= {3'h0, ~ack_in.vec};
  end
endmodule : pxu_periph
